// ==== rtl/fwhs_pkg.sv ====
/*
 * Constants and types for the width-configurable half-duplex link slave.
 * Assumes a single system clock domain; link pins are sampled, not clocked.
 */
// How it works
// - Idle: write status on line0, read status on MISO
// - Status driving while idle can be switched off
// - Command/width phase first, then data phases
// - Each data byte gets ACK or NAK on MISO
// - Width and command sampled on first edge, eight lines
// - Width priority: [7:4] 8, [3:2] 4, [1] 2, else 1
// - Highest-priority low line, command lines 3,5,6 excepted, decides the width
// - Command bits at positions 0,3,5,6; 7 counts for width only
// - Line0 released at once when selection begins
// - 1-bit: seven command clocks, eighth is turnaround
// - 1-bit data phase is eight clocks, repeats
// - ACK status set on the turnaround edge, held whole data phase
// - Write ends: master releases, slave drives write status
// - Read ends: slave goes straight to write status
package fwhs_pkg;

    // Pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    // Decoded width codes: bits per edge is 1 << code
    localparam logic [1:0] WID_1 = 2'h0;
    localparam logic [1:0] WID_2 = 2'h1;
    localparam logic [1:0] WID_4 = 2'h2;
    localparam logic [1:0] WID_8 = 2'h3;

    // Command bit positions in the first sampled word
    localparam int CMD3_POS = 0;
    localparam int CMD2_POS = 3;
    localparam int CMD1_POS = 5;
    localparam int CMD0_POS = 6;

    // Command codes for the two directions
    localparam logic [3:0] CMD_WRITE = 4'h0;
    localparam logic [3:0] CMD_READ  = 4'h1;

    // Handshake levels on MISO
    localparam logic ACK_LVL = 1'b0;
    localparam logic NAK_LVL = 1'b1;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_CNT  = 4'h0;
    localparam logic [9:0] RST_PINS = 10'h3ff;

    typedef enum logic [1:0] {
        FWHS_IDLE,
        FWHS_CMD,
        FWHS_DATA
    } fwhs_state_e;

endpackage : fwhs_pkg

// ==== rtl/fwhs_slave.sv ====
/*
 * Slave end of a half-duplex link of 1, 2, 4 or 8 data lines.
 * Assumes the master's link clock is far slower than clk (several clk
 * periods per level) and that the user buffers run on clk.
 */
`timescale 1ns/1ps
module fwhs_slave (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Link pins
    input  wire logic                 link_clk,
    input  wire logic                 ss_n,
    input  wire logic [7:0]           bidir_data_lines_i,
    output logic      [7:0]           bidir_data_lines_o,
    output logic      [7:0]           bidir_data_lines_oe,
    output logic                      miso_o,
    output logic                      miso_oe,
    // Configuration
    input  wire logic                 status_en,
    // Write buffer side
    output logic      [7:0]           wr_data,
    output logic                      wr_valid,
    input  wire logic                 wr_full,
    // Read buffer side
    input  wire logic [7:0]           rd_data,
    input  wire logic                 rd_empty,
    output logic                      rd_take,
    // Decoded command
    output logic      [3:0]           cmd_code,
    output logic      [1:0]           width_code
);
    import fwhs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Priority width decode of the first sampled word; command lines in the
    // priority ranges are masked, else most commands would force 8 lines
    function automatic logic [1:0] dec_width(input logic [7:0] d);
        logic [7:0] m;
        m           = d;
        m[CMD2_POS] = 1'b1;
        m[CMD1_POS] = 1'b1;
        m[CMD0_POS] = 1'b1;
        if (!(&m[7:4]))      dec_width = WID_8;
        else if (!(&m[3:2])) dec_width = WID_4;
        else if (!m[1])      dec_width = WID_2;
        else                 dec_width = WID_1;
    endfunction : dec_width

    // Line mask for the active width
    function automatic logic [7:0] lane_mask(input logic [1:0] w);
        unique case (w)
            WID_1: lane_mask = 8'h01;
            WID_2: lane_mask = 8'h03;
            WID_4: lane_mask = 8'h0f;
            WID_8: lane_mask = 8'hff;
        endcase
    endfunction : lane_mask

    // Edges per data byte
    function automatic logic [3:0] byte_edges(input logic [1:0] w);
        unique case (w)
            WID_1: byte_edges = 4'h8;
            WID_2: byte_edges = 4'h4;
            WID_4: byte_edges = 4'h2;
            WID_8: byte_edges = 4'h1;
        endcase
    endfunction : byte_edges

    // Edges in the command phase, last one is the turnaround
    function automatic logic [3:0] cmd_edges(input logic [1:0] w);
        unique case (w)
            WID_1: cmd_edges = 4'h8;
            WID_2: cmd_edges = 4'h4;
            WID_4: cmd_edges = 4'h2;
            WID_8: cmd_edges = 4'h2;
        endcase
    endfunction : cmd_edges

    // Shift in one chunk, LSB first
    function automatic logic [7:0] merge_in(input logic [7:0] sh,
                                            input logic [7:0] din,
                                            input logic [1:0] w);
        unique case (w)
            WID_1: merge_in = {din[0],   sh[7:1]};
            WID_2: merge_in = {din[1:0], sh[7:2]};
            WID_4: merge_in = {din[3:0], sh[7:4]};
            WID_8: merge_in = din;
        endcase
    endfunction : merge_in

    // Drop the chunk just sent
    function automatic logic [7:0] drop_out(input logic [7:0] sh,
                                            input logic [1:0] w);
        unique case (w)
            WID_1: drop_out = {1'h0, sh[7:1]};
            WID_2: drop_out = {2'h0, sh[7:2]};
            WID_4: drop_out = {4'h0, sh[7:4]};
            WID_8: drop_out = 8'h00;
        endcase
    endfunction : drop_out

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling: three stages, a change counts when 2 and 3 agree

    logic [9:0] pins;
    logic [9:0] s1_q;
    logic [9:0] s2_q;
    logic [9:0] s3_q;
    logic [9:0] stab_q;
    logic [9:0] stab_d;

    assign pins = {link_clk, ss_n, bidir_data_lines_i};

    // Per-line filter keeps the old level while stages disagree
    for (genvar i = 0; i < 10; i++) begin : g_filt
        always_comb begin
            stab_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stab_q[i];
        end
    end

    // Synchroniser stages; reset to the pulled-up idle levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q   <= RST_PINS;
            s2_q   <= RST_PINS;
            s3_q   <= RST_PINS;
            stab_q <= RST_PINS;
        end else begin
            s1_q   <= pins;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            stab_q <= stab_d;
        end
    end

    logic       lclk_rise;
    logic       sel;
    logic [7:0] din;

    assign lclk_rise = stab_d[9] & ~stab_q[9];
    assign sel       = ~stab_d[8];
    assign din       = stab_d[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Link sequencer

    fwhs_state_e state_q, state_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [3:0]  cmd_q, cmd_d;
    logic [1:0]  wid_q, wid_d;
    logic [7:0]  sh_q, sh_d;
    logic        ack_q, ack_d;
    logic [7:0]  dat_q, dat_d;
    logic [7:0]  doe_q, doe_d;
    logic        miso_q, miso_d;
    logic        moe_q, moe_d;
    logic [7:0]  wrd_q, wrd_d;
    logic        wrv_q, wrv_d;
    logic        rdt_q, rdt_d;

    // Next values; a byte boundary reuses one block for ACK and loading
    always_comb begin
        logic       start;
        logic       ok;
        logic [1:0] w;
        logic [3:0] c;
        start  = 1'b0;
        ok     = 1'b0;
        w      = wid_q;
        c      = cmd_q;
        state_d = state_q;
        cnt_d   = cnt_q;
        cmd_d   = cmd_q;
        wid_d   = wid_q;
        sh_d    = sh_q;
        ack_d   = ack_q;
        dat_d   = dat_q;
        doe_d   = doe_q;
        miso_d  = miso_q;
        moe_d   = moe_q;
        wrd_d   = wrd_q;
        wrv_d   = 1'b0;
        rdt_d   = 1'b0;
        if (!sel) begin
            // Deselected: optional buffer status on line0 and MISO
            state_d = FWHS_IDLE;
            dat_d   = {7'h00, wr_full};
            doe_d   = {7'h00, status_en};
            miso_d  = rd_empty;
            moe_d   = status_en;
        end else begin
            unique case (state_q)
                FWHS_IDLE: begin
                    doe_d  = 8'h00;
                    moe_d  = 1'b1;
                    miso_d = NAK_LVL;
                    if (lclk_rise) begin
                        // Command and width share the first word
                        w = dec_width(din);
                        c = {din[CMD3_POS], din[CMD2_POS],
                             din[CMD1_POS], din[CMD0_POS]};
                        wid_d   = w;
                        cmd_d   = c;
                        cnt_d   = cmd_edges(w) - 4'h1;
                        state_d = FWHS_CMD;
                    end
                end
                FWHS_CMD: begin
                    // Remaining command edges, then turnaround
                    if (lclk_rise) begin
                        if (cnt_q == 4'h1) begin
                            start   = 1'b1;
                            state_d = FWHS_DATA;
                        end else begin
                            cnt_d = cnt_q - 4'h1;
                        end
                    end
                end
                FWHS_DATA: begin
                    if (lclk_rise) begin
                        if (cmd_q == CMD_WRITE) begin
                            sh_d = merge_in(sh_q, din, wid_q);
                        end
                        if (cnt_q == 4'h1) begin
                            // Byte complete; hand over only if ACKed
                            if (cmd_q == CMD_WRITE && ack_q) begin
                                wrd_d = merge_in(sh_q, din, wid_q);
                                wrv_d = 1'b1;
                            end
                            start = 1'b1;
                        end else begin
                            cnt_d = cnt_q - 4'h1;
                            if (cmd_q == CMD_READ) begin
                                dat_d = sh_q & lane_mask(wid_q); // Next chunk
                                sh_d  = drop_out(sh_q, wid_q);
                            end
                        end
                    end
                end
                default: state_d = FWHS_IDLE;
            endcase
            if (start) begin
                // New byte: decide ACK now, hold it the whole phase
                if (c == CMD_WRITE)     ok = !wr_full;
                else if (c == CMD_READ) ok = !rd_empty;
                else                    ok = 1'b0;
                ack_d  = ok;
                miso_d = ok ? ACK_LVL : NAK_LVL;
                cnt_d  = byte_edges(w);
                sh_d   = RST_BYTE;
                if (c == CMD_READ) begin
                    // Read drives data lines; write leaves them to master
                    doe_d = lane_mask(w);
                    dat_d = ok ? (rd_data & lane_mask(w)) : RST_BYTE;
                    if (ok) begin
                        sh_d  = drop_out(rd_data, w);
                        rdt_d = 1'b1;
                    end
                end else begin
                    doe_d = 8'h00;
                end
            end
        end
    end

    // Register stage; every output comes straight from here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FWHS_IDLE;
            cnt_q   <= RST_CNT;
            cmd_q   <= RST_CNT;
            wid_q   <= WID_1;
            sh_q    <= RST_BYTE;
            ack_q   <= 1'b0;
            dat_q   <= RST_BYTE;
            doe_q   <= RST_BYTE;
            miso_q  <= NAK_LVL;
            moe_q   <= 1'b0;
            wrd_q   <= RST_BYTE;
            wrv_q   <= 1'b0;
            rdt_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            cmd_q   <= cmd_d;
            wid_q   <= wid_d;
            sh_q    <= sh_d;
            ack_q   <= ack_d;
            dat_q   <= dat_d;
            doe_q   <= doe_d;
            miso_q  <= miso_d;
            moe_q   <= moe_d;
            wrd_q   <= wrd_d;
            wrv_q   <= wrv_d;
            rdt_q   <= rdt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign bidir_data_lines_o  = dat_q;
    assign bidir_data_lines_oe = doe_q;
    assign miso_o              = miso_q;
    assign miso_oe             = moe_q;
    assign wr_data             = wrd_q;
    assign wr_valid            = wrv_q;
    assign rd_take             = rdt_q;
    assign cmd_code            = cmd_q;
    assign width_code          = wid_q;

endmodule : fwhs_slave

// ==== verif/fwhs_slave_assertions.sv ====
/* Port checker for the link slave.
   Assumes a bind onto fwhs_slave and the single clk domain. */
`timescale 1ns/1ps
module fwhs_slave_assertions (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Link and user side
    input wire logic       ss_n,
    input wire logic       status_en,
    input wire logic       wr_full,
    input wire logic       rd_empty,
    input wire logic [7:0] bidir_data_lines_o,
    input wire logic [7:0] bidir_data_lines_oe,
    input wire logic       miso_o,
    input wire logic       miso_oe,
    input wire logic       wr_valid,
    input wire logic       rd_take,
    input wire logic [3:0] cmd_code,
    input wire logic [1:0] width_code
);
    import fwhs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////
    // Eight cycles cover the pin synchroniser plus one register
    idle_line0_a: assert property (
        (ss_n && status_en && $stable(wr_full))[*8] |->
        bidir_data_lines_oe[0] && bidir_data_lines_o[0] == wr_full)
        else $error("idle line0 status wrong");
    idle_miso_a: assert property (
        (ss_n && status_en && $stable(rd_empty))[*8] |-> miso_oe && miso_o == rd_empty)
        else $error("idle miso status wrong");
    idle_quiet_a: assert property (
        (ss_n && !status_en)[*8] |-> !miso_oe && !bidir_data_lines_oe[0])
        else $error("status driven while switched off");
    sel_release_a: assert property (
        $fell(ss_n) |-> ##5 !bidir_data_lines_oe[0])
        else $error("line0 not released on select");
    sel_miso_a: assert property (
        (!ss_n)[*6] |-> miso_oe)
        else $error("miso not driven while selected");
    narrow_lines_a: assert property (
        width_code == WID_1 |-> bidir_data_lines_oe[7:1] == 7'h00)
        else $error("upper lines driven in 1-bit mode");
    wr_accept_a: assert property (
        wr_valid |-> cmd_code == CMD_WRITE && $past(miso_o) == ACK_LVL ##1 !wr_valid)
        else $error("write byte taken without ack");
    rd_pop_a: assert property (
        rd_take |-> cmd_code == CMD_READ && !$past(rd_empty) ##1 !rd_take)
        else $error("read pop without data");
    wr_quiet_a: assert property (
        (!ss_n)[*6] ##0 cmd_code == CMD_WRITE |-> !bidir_data_lines_oe[0])
        else $error("line0 driven during write");
    rd_hold_a: assert property (
        bidir_data_lines_oe[0] && cmd_code == CMD_READ && status_en
        |=> bidir_data_lines_oe[0] || !ss_n)
        else $error("line0 gap after read");
endmodule : fwhs_slave_assertions

// ==== verif/fwhs_master_model.sv ====
/* Link master model: clock, select and pulled-up data lines.
   Assumes callers enter its tasks at a rising edge of clk. */
`timescale 1ns/1ps
module fwhs_master_model (
    // System clock
    input wire logic       clk,
    // Link pins
    output logic           link_clk,
    output logic           ss_n,
    output logic     [7:0] lines,
    input wire logic [7:0] s_o,
    input wire logic [7:0] s_oe
);
    logic [7:0] m_o;
    logic [7:0] m_oe;
    // Every line pulled up, so a released line reads one
    assign lines = (s_oe & s_o) | (~s_oe & m_oe & m_o) | (~s_oe & ~m_oe);
    initial begin
        link_clk = 1'b0;
        ss_n     = 1'b1;
        m_o      = 8'hff;
        m_oe     = 8'h00;
    end
////////////////////////////////////////////////////////////////////////
    task automatic hp();
        repeat (8) @(posedge clk);
    endtask : hp
    // One period: change on the fall, slave samples on the rise
    task automatic tick(input logic [7:0] d, input logic [7:0] oe, output logic [7:0] s);
        link_clk <= 1'b0;
        m_o      <= d;
        m_oe     <= oe;
        hp();
        link_clk <= 1'b1;
        hp();
        s = lines;
    endtask : tick
    task automatic start(input logic [7:0] w);
        logic [7:0] s;
        ss_n <= 1'b0;
        hp();                // Slave lets go of line0 first
        tick(w, 8'hff, s);   // Width and command on all eight lines
    endtask : start
    task automatic stop();
        link_clk <= 1'b0;
        m_oe     <= 8'h00;   // Release before deselect
        hp();
        ss_n     <= 1'b1;    // Also the abort after a refusal
        hp();
        hp();
    endtask : stop
    // 1-bit transfer of one byte, preceded by the turnaround edge
    task automatic run(input logic [7:0] w, input logic [7:0] d, input logic wr,
                       output logic [7:0] rx);
        logic [7:0] s;
        logic [8:0] sh;
        sh = {d, 1'b1};
        start(w);
        repeat (6) tick(w, 8'h01, s);  // Command clocks 2 to 7
        for (int i = 0; i < 9; i++) begin
            tick({7'h7f, sh[i]}, {7'h00, wr && (i > 0)}, s);
            if (i < 8) rx[i] = s[0];
        end
    endtask : run
endmodule : fwhs_master_model

// ==== verif/tb_fwhs_slave.sv ====
/* Self-checking bench for the link slave.
   Assumes the master model drives the link and the bench the user side. */
`timescale 1ns/1ps
module tb_fwhs_slave;
    import fwhs_pkg::*;
    logic       clk, rst_n, link_clk, ss_n, status_en, wr_full, rd_empty;
    logic       miso_o, miso_oe, wr_valid, rd_take;
    logic [7:0] lines, s_o, s_oe, rd_data, wr_data, last_wr;
    logic [3:0] cmd_code;
    logic [1:0] width_code;
    int         n_mismatch = 0;
    int         n_tests = 0;
    int         n_wr = 0;
    int         n_rd = 0;
    fwhs_slave u_dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .ss_n(ss_n),
        .bidir_data_lines_i(lines), .bidir_data_lines_o(s_o), .bidir_data_lines_oe(s_oe),
        .miso_o(miso_o), .miso_oe(miso_oe), .status_en(status_en), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_full(wr_full), .rd_data(rd_data), .rd_empty(rd_empty),
        .rd_take(rd_take), .cmd_code(cmd_code), .width_code(width_code));
    fwhs_master_model u_mst (.clk(clk), .link_clk(link_clk), .ss_n(ss_n), .lines(lines),
        .s_o(s_o), .s_oe(s_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Count user-side pulses; a pulse lasts one cycle
    always @(posedge clk) begin
        if (wr_valid === 1'b1) begin
            n_wr++;
            last_wr = wr_data;
        end
        if (rd_take === 1'b1) n_rd++;
    end
////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic t_idle();
        wr_full  <= 1'b1;
        rd_empty <= 1'b0;
        repeat (8) @(posedge clk);
        check("idle line0", {6'h0, s_oe[0], s_o[0]}, 8'h03);
        check("idle miso", {6'h0, miso_oe, miso_o}, 8'h02);
        status_en <= 1'b0;
        repeat (8) @(posedge clk);
        check("quiet", {6'h0, s_oe[0], miso_oe}, 8'h00);
        status_en <= 1'b1;
    endtask : t_idle
    // Priority width decode and command bit placement
    task automatic t_width();
        logic [7:0] w [4] = '{8'hff, 8'hfd, 8'hf1, 8'h87};
        logic [1:0] e [4] = '{WID_1, WID_2, WID_4, WID_8};
        for (int k = 0; k < 4; k++) begin
            u_mst.start(w[k]);
            u_mst.stop();
            check("width", {6'h0, width_code}, {6'h0, e[k]});
            check("cmd", {4'h0, cmd_code}, {4'h0, w[k][0], w[k][3], w[k][5], w[k][6]});
        end
    endtask : t_width
    task automatic t_write(input logic full);
        logic [7:0] rx;
        wr_full <= full;
        n_wr = 0;
        u_mst.run(8'h96, 8'ha5, 1'b1, rx);
        check("wr ack", {7'h0, miso_o}, {7'h0, full});
        check("wr count", 8'(n_wr), {7'h0, !full});
        if (!full) check("wr byte", last_wr, 8'ha5);
        u_mst.stop();
        check("wr end", {6'h0, s_oe[0], s_o[0]}, {7'h01, full});
    endtask : t_write
    task automatic t_read(input logic empty);
        logic [7:0] rx;
        rd_empty <= empty;
        rd_data  <= 8'h3c;
        n_rd = 0;
        u_mst.run(8'hd6, 8'h00, 1'b0, rx);
        check("rd ack", {7'h0, miso_o}, {7'h0, empty});
        check("rd byte", rx, empty ? 8'h00 : 8'h3c);
        check("rd pops", 8'(n_rd), empty ? 8'h00 : 8'h02);
        u_mst.stop();
        check("rd end", {6'h0, s_oe[0], s_o[0]}, {7'h01, wr_full});
    endtask : t_read
    // Eight-line write then read: one edge per byte after the turnaround edge
    task automatic t_wide();
        logic [7:0] s;
        wr_full  <= 1'b0;
        rd_empty <= 1'b0;
        rd_data  <= 8'h69;
        n_wr = 0;
        n_rd = 0;
        u_mst.start(8'h86);                // Line 4 low, command write
        u_mst.tick(8'hff, 8'h00, s);       // Turnaround edge
        u_mst.tick(8'h5a, 8'hff, s);       // Whole byte on one edge
        check("wide width", {6'h0, width_code}, {6'h0, WID_8});
        check("wide wr", last_wr, 8'h5a);
        check("wide wr count", 8'(n_wr), 8'h01);
        u_mst.stop();
        u_mst.start(8'hc6);                // Line 4 low, command read
        u_mst.tick(8'hff, 8'h00, s);       // Slave drives all lines after this edge
        check("wide rd", s, 8'h69);
        check("wide rd pops", 8'(n_rd), 8'h01);
        u_mst.stop();
    endtask : t_wide
////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n     = 1'b0;
        status_en = 1'b1;
        wr_full   = 1'b0;
        rd_empty  = 1'b1;
        rd_data   = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_idle();
        t_width();
        t_write(1'b0);
        t_write(1'b1);
        t_read(1'b0);
        t_read(1'b1);
        t_wide();
        results();
    end
    // Whole run is about 1500 cycles; far beyond that is a hang
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule : tb_fwhs_slave
bind fwhs_slave fwhs_slave_assertions u_chk (.clk(clk), .rst_n(rst_n), .ss_n(ss_n),
    .status_en(status_en), .wr_full(wr_full), .rd_empty(rd_empty),
    .bidir_data_lines_o(bidir_data_lines_o), .bidir_data_lines_oe(bidir_data_lines_oe),
    .miso_o(miso_o), .miso_oe(miso_oe), .wr_valid(wr_valid), .rd_take(rd_take),
    .cmd_code(cmd_code), .width_code(width_code));
